// file: include/hbd_defs.vh
// Constants for the bridge driver serial command and diagnosis block
`ifndef HBD_DEFS_VH
`define HBD_DEFS_VH
// Frame
`define HBD_FRAME_BITS      5'd16
`define HBD_VERIFY_PAT      5'h15
// Command codes (frame bits 13:8 with id bits 15:14 = 00)
`define HBD_CMD_WR_CFG      6'h33
`define HBD_CMD_IDENT       6'h00
`define HBD_CMD_REVISION    6'h03
`define HBD_CMD_CFG_READ    6'h28
`define HBD_CMD_DIAG        6'h09
`define HBD_CHIP_ID         2'h0
// Configuration field positions
`define HBD_CFG_LIM_LSB     2
`define HBD_CFG_EN1         4
`define HBD_CFG_EN2         5
`define HBD_CFG_PUMP        6
`define HBD_CFG_PINFN       7
// Configuration reset value: limit code 10, both outputs on, full pump power, enable input
`define HBD_CFG_RESET       8'h38
// Diagnosis codes
`define HBD_DIAG_NORMAL     2'h3
`define HBD_DIAG_SHORT_VS   2'h1
`define HBD_DIAG_SHORT_GND  2'h2
`define HBD_DIAG_OFF        2'h0
`define HBD_DIAG_POR        4'h0
// Arbitrary identity and revision values
`define HBD_IDENT_CODE      8'h5a
`define HBD_DESIGN_REV      4'h2
`define HBD_MASK_REV        4'h3
`endif

// file: core/hbd_sync.v
// Two-flop synchroniser bank for asynchronous pin inputs
`default_nettype none
module hbd_sync #(
  parameter W = 1
) (
  // Clock
  input  wire         sys_clk,
  input  wire         rst,
  // Data
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] meta_q;

  always @(posedge sys_clk) begin
    if (rst) begin
      meta_q   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // hbd_sync
`default_nettype wire

// file: core/hbd_diag.v
// Per-output priority-encoded diagnosis latch with undervoltage overlay
`default_nettype none
`include "hbd_defs.vh"
module hbd_diag (
  // Clock
  input  wire       sys_clk,
  input  wire       rst,
  // Fault inputs, already synchronised
  input  wire       undervolt,
  input  wire       shorted_load,
  input  wire       out1_short_vs,
  input  wire       out1_short_gnd,
  input  wire       out2_short_vs,
  input  wire       out2_short_gnd,
  input  wire       open_load,
  input  wire       clear,
  // Diagnosis word out: out2 hi, out2 lo, out1 hi, out1 lo
  output wire [3:0] diag_word
);
  reg  [3:0] latched_q;
  reg  [3:0] event_d;
  reg        por_q;

  function [1:0] out_code;
    input vs;
    input gnd;
    begin
      if (vs)
        out_code = `HBD_DIAG_SHORT_VS;
      else if (gnd)
        out_code = `HBD_DIAG_SHORT_GND;
      else
        out_code = `HBD_DIAG_NORMAL;
    end
  endfunction

  function [1:0] rank;
    input [3:0] w;
    begin
      if (w == 4'hc)
        rank = 2'd3;
      else if (w == 4'hf)
        rank = 2'd0;
      else if (w == 4'h3)
        rank = 2'd1;
      else
        rank = 2'd2;
    end
  endfunction

  // Priority: shorted load over shorts over open load
  always @* begin
    event_d = 4'hf;
    if (shorted_load)
      event_d = 4'hc;
    else if (out1_short_vs | out1_short_gnd | out2_short_vs | out2_short_gnd)
      event_d = {out_code(out2_short_vs, out2_short_gnd), out_code(out1_short_vs, out1_short_gnd)};
    else if (open_load)
      event_d = 4'h3;
  end

  // Only an equal- or higher-ranked fault overwrites, except that any fault replaces the power-on code; a new fault beats a same-cycle clear
  always @(posedge sys_clk) begin
    if (rst) begin
      latched_q <= `HBD_DIAG_POR;
      por_q     <= 1'b1;
    end else if (event_d != 4'hf && (por_q || clear || rank(event_d) >= rank(latched_q))) begin
      latched_q <= event_d;
      por_q     <= 1'b0;
    end else if (clear) begin
      latched_q <= 4'hf;
      por_q     <= 1'b0;
    end
  end

  // Undervoltage masks without touching the latch, so codes return afterwards
  assign diag_word = undervolt ? 4'h0 : latched_q;
endmodule // hbd_diag
`default_nettype wire

// file: core/hbd_spi_core.v
// Serial command interpreter and configuration/status logic of the bridge driver
//
// Contract
// - Two-bit limit field picks one of four current levels, code 10 default.
// - Pin-function bit: 0 enable input, 1 status flag output.
// - Per-output enable bits, default on, combine with pins into enabled status.
// - Enabled status shows present state, never latched.
// - Per-output diagnosis code: 01 short supply, 10 short ground, 11 normal; latched.
// - Open load 00/11, shorted load 11/00, both latched.
// - Undervoltage forces diagnosis to zero, unlatched, highest priority.
// - Higher priority fault overwrites lower one.
// - Latched codes return when undervoltage ends.
// - Configuration write returns diagnosis without clearing it.
// - Clear by enable pin rise or diagnosis read erases latched diagnosis; only diagnosis read also resets status flags.
// - Power-on sets diagnosis to 0000, held latched.
// - Overcurrent flag latches 0 on excess current, reads 1 otherwise.
// - Derate and overtemperature flags latch 0, read 1 otherwise.
// - Frame error flag 0 after valid frame, 1 latched after error.
// - Response bits 13..9 always 10101.
// - Identity read returns fixed eight-bit code in low byte.
// - Revision read returns two fixed nibbles in low byte.
// - Write commits at select rise only with valid id, command, sixteen clocks.
// - Sample input on falling clock, shift output on rising; float unless id valid.
// - Configuration changes only while outputs-enabled status is 0.
// - Diagnosis read returns word then clears latched data.
`default_nettype none
`include "hbd_defs.vh"
module hbd_spi_core (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Serial pins
  input  wire       chip_select_pin_n,
  input  wire       sclk_pin,
  input  wire       sdi_pin,
  output reg        sdo_out,
  output reg        sdo_oe_n,
  // Enable pins
  input  wire       enable_pin,
  input  wire       disable_pin_in,
  output reg        disable_flag_pin_out,
  output reg        disable_flag_pin_oe_n,
  // Analog fault events
  input  wire       undervolt_in,
  input  wire       shorted_load_in,
  input  wire       out1_short_vs_in,
  input  wire       out1_short_gnd_in,
  input  wire       out2_short_vs_in,
  input  wire       out2_short_gnd_in,
  input  wire       open_load_in,
  input  wire       overcurrent_in,
  input  wire       derate_temp_in,
  input  wire       shutdown_temp_in,
  // Configuration to power stage
  output reg  [1:0] selected_current_level,
  output reg        out1_active,
  output reg        out2_active,
  output reg        pump_power_select
);
  ////////////////////////////////////////////////////////////////////////////
  wire [12:0] pins_s;
  wire        cs_sel_s;
  wire        cs_n_s;
  wire        sclk_s;
  wire        sdi_s;
  wire        en_s;
  wire        dis_s;
  wire        uv_s;
  wire        sl_s;
  wire        o1v_s;
  wire        o1g_s;
  wire        o2v_s;
  wire        o2g_s;
  wire        ol_s;
  wire        oc_s;
  wire        tl_s;
  wire        ts_s;
  wire [3:0]  diag_word;

  reg         cs_n_prev_q;
  reg         sclk_prev_q;
  reg  [15:0] rx_q;
  reg  [4:0]  bit_cnt_q;
  reg         cnt_over_q;
  reg  [15:0] tx_q;
  reg  [7:0]  cfg_q;
  reg         oc_flag_q;
  reg         derate_flag_q;
  reg         ot_flag_q;
  reg         frame_err_q;
  reg         diag_clr_q;
  reg         en_prev_q;
  reg  [7:0]  status_byte;
  reg         id_ok;
  reg         cmd_ok;
  reg         frame_ok;
  reg         enabled_now;
  reg         pin_enable;

  wire cs_fall = cs_n_prev_q & ~cs_n_s;
  wire cs_rise = ~cs_n_prev_q & cs_n_s;
  wire sclk_rise = ~sclk_prev_q & sclk_s;
  wire sclk_fall = sclk_prev_q & ~sclk_s;

  // Pins cross into sys_clk before anything looks at them
  hbd_sync #(.W(13)) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({~chip_select_pin_n, sclk_pin, sdi_pin, enable_pin, disable_pin_in,
                undervolt_in, shorted_load_in, out1_short_vs_in, out1_short_gnd_in,
                out2_short_vs_in, out2_short_gnd_in, open_load_in, overcurrent_in}),
    .sync_out (pins_s)
  );
  assign {cs_sel_s, sclk_s, sdi_s, en_s, dis_s, uv_s, sl_s, o1v_s, o1g_s, o2v_s, o2g_s, ol_s, oc_s} = pins_s;
  // Select crosses inverted so its reset value is the idle level; no false frame edge after reset
  assign cs_n_s = ~cs_sel_s;

  hbd_sync #(.W(2)) u_sync_temp (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({derate_temp_in, shutdown_temp_in}),
    .sync_out ({tl_s, ts_s})
  );

  hbd_diag u_diag (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .undervolt      (uv_s),
    .shorted_load   (sl_s),
    .out1_short_vs  (o1v_s),
    .out1_short_gnd (o1g_s),
    .out2_short_vs  (o2v_s),
    .out2_short_gnd (o2g_s),
    .open_load      (ol_s),
    .clear          (diag_clr_q),
    .diag_word      (diag_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Enable status and response assembly
  always @* begin
    // As flag output the pin no longer gates the bridge
    pin_enable  = en_s & (cfg_q[`HBD_CFG_PINFN] | ~dis_s);
    enabled_now = pin_enable & (cfg_q[`HBD_CFG_EN1] | cfg_q[`HBD_CFG_EN2]);
    status_byte = {enabled_now, ot_flag_q, derate_flag_q, oc_flag_q, diag_word};
    id_ok       = (rx_q[15:14] == `HBD_CHIP_ID);
    case (rx_q[13:8])
      `HBD_CMD_WR_CFG, `HBD_CMD_DIAG, `HBD_CMD_IDENT, `HBD_CMD_REVISION, `HBD_CMD_CFG_READ:
        cmd_ok = 1'b1;
      default:
        cmd_ok = 1'b0;
    endcase
    frame_ok = id_ok & cmd_ok & (bit_cnt_q == `HBD_FRAME_BITS) & ~cnt_over_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial shifter: sample on falling clock, shift out on rising clock
  always @(posedge sys_clk) begin
    if (rst) begin
      cs_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      rx_q        <= 16'h0000;
      bit_cnt_q   <= 5'h00;
      cnt_over_q  <= 1'b0;
      tx_q        <= 16'h0000;
      sdo_out     <= 1'b0;
      sdo_oe_n    <= 1'b1;
    end else begin
      cs_n_prev_q <= cs_n_s;
      sclk_prev_q <= sclk_s;
      if (cs_fall) begin
        bit_cnt_q  <= 5'h00;
        cnt_over_q <= 1'b0;
        // First response bits are the floating id slot; response is built from current state
        tx_q       <= {2'b00, `HBD_VERIFY_PAT, frame_err_q, status_byte};
        sdo_out    <= 1'b0;
        sdo_oe_n   <= 1'b1;
      end else if (!cs_n_s) begin
        if (sclk_fall) begin
          rx_q <= {rx_q[14:0], sdi_s};
          if (bit_cnt_q == `HBD_FRAME_BITS)
            cnt_over_q <= 1'b1;
          else
            bit_cnt_q <= bit_cnt_q + 5'd1;
          // The eighth bit completes the command while the upper byte is already out;
          // the reply byte must sit on top before the ninth rising clock
          if (bit_cnt_q == 5'd7)
            tx_q <= {resp_low_pre({rx_q[4:0], sdi_s}, status_byte, cfg_q, ot_flag_q, derate_flag_q), 8'h00};
        end
        if (sclk_rise) begin
          tx_q    <= {tx_q[14:0], 1'b0};
          sdo_out <= tx_q[15];
          // Id is judged once, at the third rising clock; later bits would overwrite it
          if (bit_cnt_q == 5'd2)
            sdo_oe_n <= (rx_q[1:0] != `HBD_CHIP_ID);
        end
      end else begin
        sdo_oe_n <= 1'b1;
      end
    end
  end

  function [7:0] resp_low_pre;
    input [5:0] cmd;
    input [7:0] st;
    input [7:0] cfg;
    input       ot;
    input       dr;
    begin
      case (cmd)
        `HBD_CMD_WR_CFG:   resp_low_pre = st;
        `HBD_CMD_DIAG:     resp_low_pre = st;
        `HBD_CMD_IDENT:    resp_low_pre = `HBD_IDENT_CODE;
        `HBD_CMD_REVISION: resp_low_pre = {`HBD_DESIGN_REV, `HBD_MASK_REV};
        `HBD_CMD_CFG_READ: resp_low_pre = {cfg[7:2], ~ot ? 2'b00 : {1'b1, dr}};
        default:           resp_low_pre = 8'hff;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Commit at chip-select rise; flags and configuration
  always @(posedge sys_clk) begin
    if (rst) begin
      cfg_q         <= `HBD_CFG_RESET;
      frame_err_q   <= 1'b0;
      oc_flag_q     <= 1'b1;
      derate_flag_q <= 1'b1;
      ot_flag_q     <= 1'b1;
      diag_clr_q    <= 1'b0;
      en_prev_q     <= 1'b0;
    end else begin
      en_prev_q  <= en_s;
      // Enable pin rising edge resets diagnosis
      diag_clr_q <= en_s & ~en_prev_q;
      if (cs_rise) begin
        frame_err_q <= ~frame_ok;
        if (frame_ok && rx_q[13:8] == `HBD_CMD_DIAG) begin
          diag_clr_q    <= 1'b1;
          oc_flag_q     <= 1'b1;
          derate_flag_q <= 1'b1;
          ot_flag_q     <= 1'b1;
        end
        // Reserved bits 1:0 dropped
        if (frame_ok && rx_q[13:8] == `HBD_CMD_WR_CFG && !enabled_now)
          cfg_q <= {rx_q[7:2], 2'b00};
      end
      // Fault set wins over a same-cycle clear
      if (oc_s)
        oc_flag_q <= 1'b0;
      if (tl_s)
        derate_flag_q <= 1'b0;
      if (ts_s)
        ot_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs to the power stage and flag pin
  always @(posedge sys_clk) begin
    if (rst) begin
      selected_current_level <= 2'h2;
      out1_active            <= 1'b0;
      out2_active            <= 1'b0;
      pump_power_select      <= 1'b0;
      disable_flag_pin_out   <= 1'b0;
      disable_flag_pin_oe_n  <= 1'b1;
    end else begin
      selected_current_level <= cfg_q[`HBD_CFG_LIM_LSB+1:`HBD_CFG_LIM_LSB];
      out1_active            <= pin_enable & cfg_q[`HBD_CFG_EN1];
      out2_active            <= pin_enable & cfg_q[`HBD_CFG_EN2];
      pump_power_select      <= cfg_q[`HBD_CFG_PUMP];
      // Flag output pulls low on any latched status fault
      disable_flag_pin_out   <= oc_flag_q & derate_flag_q & ot_flag_q;
      disable_flag_pin_oe_n  <= ~cfg_q[`HBD_CFG_PINFN];
    end
  end
endmodule // hbd_spi_core
`default_nettype wire

// file: sim/hbd_spi_core_props.sv
// Concurrent checks on the bridge driver serial core ports
`default_nettype none
module hbd_spi_core_props (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Pins
  input wire logic       chip_select_pin_n,
  input wire logic       sdo_oe_n,
  input wire logic       enable_pin,
  input wire logic       disable_flag_pin_out,
  input wire logic       disable_flag_pin_oe_n,
  input wire logic       overcurrent_in,
  input wire logic       derate_temp_in,
  input wire logic       shutdown_temp_in,
  // Configuration outputs
  input wire logic [1:0] selected_current_level,
  input wire logic       out1_active,
  input wire logic       out2_active,
  input wire logic       pump_power_select
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  a_reset_state: assert property (@(posedge sys_clk) disable iff (1'b0) rst [*2] |-> sdo_oe_n && disable_flag_pin_oe_n
    && selected_current_level == 2'h2 && !out1_active && !out2_active) else $error("outputs wrong during reset");
  a_float_idle: assert property (chip_select_pin_n [*5] |-> sdo_oe_n) else $error("data out driven while deselected");
  a_float_sel: assert property ($fell(sdo_oe_n) |-> !chip_select_pin_n) else $error("data out driven outside frame");
  a_cfg_commit: assert property ($changed(selected_current_level) |-> chip_select_pin_n && $past(chip_select_pin_n))
    else $error("limit changed inside frame");
  a_pump_commit: assert property ($changed(pump_power_select) |-> chip_select_pin_n) else $error("pump mode changed in frame");
  a_cfg_locked: assert property ($changed(selected_current_level) |-> !$past(out1_active, 2) && !$past(out2_active, 2))
    else $error("configuration changed while enabled");
  a_enable_pin: assert property (!enable_pin [*6] |-> !out1_active && !out2_active) else $error("output on with pin low");
  a_pin_fn: assert property ($fell(disable_flag_pin_oe_n) |-> chip_select_pin_n) else $error("flag pin mode changed in frame");
  a_oc_flag: assert property ($rose(overcurrent_in) ##6 !disable_flag_pin_oe_n |-> !disable_flag_pin_out)
    else $error("overcurrent not flagged");
  a_temp_flag: assert property (($rose(derate_temp_in) || $rose(shutdown_temp_in)) ##6 !disable_flag_pin_oe_n
    |-> !disable_flag_pin_out) else $error("temperature not flagged");
  c_pump: cover property ($fell(pump_power_select));
  c_enable: cover property ($rose(out1_active));
  c_flag: cover property (!disable_flag_pin_out && !disable_flag_pin_oe_n);
endmodule // hbd_spi_core_props

bind hbd_spi_core hbd_spi_core_props u_props (.sys_clk, .rst, .chip_select_pin_n, .sdo_oe_n, .enable_pin,
  .disable_flag_pin_out, .disable_flag_pin_oe_n, .overcurrent_in, .derate_temp_in, .shutdown_temp_in,
  .selected_current_level, .out1_active, .out2_active, .pump_power_select);
`default_nettype wire

// file: sim/hbd_host_model.sv
// Serial host model that clocks frames into the bridge driver
`default_nettype none
module hbd_host_model (
  // Clock
  input  wire logic sys_clk,
  // Serial pins
  output var  logic chip_select_pin_n,
  output var  logic sclk_pin,
  output var  logic sdi_pin,
  input  wire logic sdo_out,
  input  wire logic sdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sdo_w;
  // Floated output reads as z so a driven bit never passes for a released one
  assign sdo_w = sdo_oe_n ? 1'bz : sdo_out;
  initial begin
    chip_select_pin_n = 1'b1;
    sclk_pin = 1'b0;
    sdi_pin = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0;
    @(posedge sys_clk) chip_select_pin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      sclk_pin <= 1'b1;
      sdi_pin <= w[15-i];
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk) r = {r[14:0], sdo_w};
      @(posedge sys_clk) sclk_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    // Released data line shows no stale bit
    sdi_pin <= ~sdi_pin;
    chip_select_pin_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule // hbd_host_model
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the bridge driver serial core
`default_nettype none
`include "hbd_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk, rst, enable_pin, disable_pin_in;
  logic [9:0] flt;
  wire        chip_select_pin_n, sclk_pin, sdi_pin, sdo_out, sdo_oe_n, disable_flag_pin_out, disable_flag_pin_oe_n;
  wire  [1:0] selected_current_level;
  wire        out1_active, out2_active, pump_power_select;
  int         n_errors, n_tests;
  localparam int UV = 9, SL = 8, O1V = 7, O1G = 6, O2V = 5, O2G = 4, OL = 3, OC = 2, DR = 1, SD = 0;

  hbd_spi_core dut (.sys_clk, .rst, .chip_select_pin_n, .sclk_pin, .sdi_pin, .sdo_out, .sdo_oe_n, .enable_pin,
    .disable_pin_in, .disable_flag_pin_out, .disable_flag_pin_oe_n, .undervolt_in(flt[UV]), .shorted_load_in(flt[SL]),
    .out1_short_vs_in(flt[O1V]), .out1_short_gnd_in(flt[O1G]), .out2_short_vs_in(flt[O2V]),
    .out2_short_gnd_in(flt[O2G]), .open_load_in(flt[OL]), .overcurrent_in(flt[OC]), .derate_temp_in(flt[DR]),
    .shutdown_temp_in(flt[SD]), .selected_current_level, .out1_active, .out2_active, .pump_power_select);
  hbd_host_model host (.sys_clk, .chip_select_pin_n, .sclk_pin, .sdi_pin, .sdo_out, .sdo_oe_n);

  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] rsp(input logic tf, input logic [7:0] lo);
    return {2'hz, 5'h15, tf, lo};
  endfunction
  task automatic frm(input logic [5:0] c, input logic [7:0] d, output logic [15:0] r);
    host.xfer({`HBD_CHIP_ID, c, d}, 16, r);
  endtask
  // Fault events are short pulses; the core must hold them itself
  task automatic pulse(input int b);
    flt[b] <= 1'b1;
    repeat (5) @(posedge sys_clk);
    flt[b] <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [15:0] r;
    chk({14'h0, selected_current_level}, 16'h2);
    frm(`HBD_CMD_IDENT, 8'h0, r);
    chk(r, rsp(1'b0, `HBD_IDENT_CODE));
    frm(`HBD_CMD_REVISION, 8'h0, r);
    chk(r, rsp(1'b0, {`HBD_DESIGN_REV, `HBD_MASK_REV}));
    frm(`HBD_CMD_DIAG, 8'h0, r);
    chk(r, rsp(1'b0, 8'h70));
    frm(`HBD_CMD_DIAG, 8'h0, r);
    chk(r, rsp(1'b0, 8'h7f));
    $display("test reset done");
  endtask
  task automatic t_config();
    logic [15:0] r;
    for (int c = 3; c >= 0; c--) begin
      frm(`HBD_CMD_WR_CFG, {1'b0, c[0], 2'h3, c[1:0], 2'h3}, r);
      chk(r, rsp(1'b0, 8'h7f));
      chk({13'h0, pump_power_select, selected_current_level}, {13'h0, c[0], c[1:0]});
    end
    frm(`HBD_CMD_WR_CFG, 8'h3b, r);
    chk({14'h0, selected_current_level}, 16'h2);
    frm(`HBD_CMD_CFG_READ, 8'h0, r);
    chk(r, rsp(1'b0, 8'h3b));
    $display("test config done");
  endtask
  task automatic t_lock();
    logic [15:0] r;
    enable_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({14'h0, out1_active, out2_active}, 16'h3);
    disable_pin_in <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({14'h0, out1_active, out2_active}, 16'h0);
    disable_pin_in <= 1'b0;
    repeat (8) @(posedge sys_clk);
    frm(`HBD_CMD_WR_CFG, 8'h30, r);
    chk(r, rsp(1'b0, 8'hff));
    chk({14'h0, selected_current_level}, 16'h2);
    enable_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    frm(`HBD_CMD_DIAG, 8'h0, r);
    chk(r, rsp(1'b0, 8'h7f));
    $display("test lock done");
  endtask
  task automatic t_diag();
    logic [15:0] r;
    int          b[6] = '{O1G, O1V, O2G, O2V, SL, OL};
    logic [3:0]  nib[6] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3};
    for (int i = 0; i < 6; i++) begin
      pulse(b[i]);
      frm(`HBD_CMD_DIAG, 8'h0, r);
      chk(r, rsp(1'b0, {4'h7, nib[i]}));
      frm(`HBD_CMD_DIAG, 8'h0, r);
      chk(r, rsp(1'b0, 8'h7f));
    end
    $display("test diag done");
  endtask
  task automatic t_prio();
    logic [15:0] r;
    pulse(O1G);
    pulse(SL);
    frm(`HBD_CMD_DIAG, 8'h0, r);
    chk(r, rsp(1'b0, 8'h7c));
    pulse(O2G);
    flt[UV] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    frm(`HBD_CMD_WR_CFG, 8'h3b, r);
    chk(r, rsp(1'b0, 8'h70));
    flt[UV] <= 1'b0;
    repeat (6) @(posedge sys_clk);
    frm(`HBD_CMD_WR_CFG, 8'h3b, r);
    chk(r, rsp(1'b0, 8'h7b));
    frm(`HBD_CMD_WR_CFG, 8'h3b, r);
    chk(r, rsp(1'b0, 8'h7b));
    enable_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    enable_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    frm(`HBD_CMD_DIAG, 8'h0, r);
    chk(r, rsp(1'b0, 8'h7f));
    $display("test priority done");
  endtask
  task automatic t_flags();
    logic [15:0] r;
    int          b[3] = '{OC, DR, SD};
    logic [7:0]  lo[3] = '{8'h6f, 8'h5f, 8'h3f};
    frm(`HBD_CMD_WR_CFG, 8'hbb, r);
    for (int i = 0; i < 3; i++) begin
      pulse(b[i]);
      chk({14'h0, disable_flag_pin_oe_n, disable_flag_pin_out}, 16'h0);
      frm(`HBD_CMD_DIAG, 8'h0, r);
      chk(r, rsp(1'b0, lo[i]));
    end
    frm(`HBD_CMD_WR_CFG, 8'h3b, r);
    chk({14'h0, disable_flag_pin_oe_n, disable_flag_pin_out}, 16'h3);
    $display("test flags done");
  endtask
  task automatic t_frame();
    logic [15:0] r;
    frm(6'h3f, 8'h0, r);
    chk(r, rsp(1'b0, 8'hff));
    frm(`HBD_CMD_IDENT, 8'h0, r);
    chk(r, rsp(1'b1, `HBD_IDENT_CODE));
    host.xfer({`HBD_CHIP_ID, `HBD_CMD_WR_CFG, 8'h33}, 15, r);
    chk({14'h0, selected_current_level}, 16'h2);
    frm(`HBD_CMD_IDENT, 8'h0, r);
    chk(r, rsp(1'b1, `HBD_IDENT_CODE));
    host.xfer(16'h4000, 16, r);
    chk(r, 16'hzzzz);
    $display("test frame done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    enable_pin = 1'b0;
    disable_pin_in = 1'b0;
    flt = 10'h0;
    n_errors = 0;
    n_tests = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_config();
    t_lock();
    t_diag();
    t_prio();
    t_flags();
    t_frame();
    complete_run();
  end
  // About 40 frames of some 150 cycles each; the limit leaves wide margin
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    complete_run();
  end
endmodule // testbench
`default_nettype wire
